// *** drvsf_regs.svh ***
`ifndef DRVSF_REGS_SVH
`define DRVSF_REGS_SVH
`define DRVSF_CLK_HZ 250000000
`define DRVSF_BAUD0 2400
`define DRVSF_BAUD1 4800
`define DRVSF_BAUD2 9600
`define DRVSF_BAUD3 19200
`define DRVSF_BAUD4 38400
`define DRVSF_BAUD5 57600
`define DRVSF_BAUD6 76800
`define DRVSF_BAUD7 115200
`define DRVSF_START_CHAR 8'h02
`define DRVSF_LEN_OVH 8'h02
`define DRVSF_PAR_EVEN 2'h0
`define DRVSF_PAR_ODD 2'h1
`define DRVSF_PAR_NONE2 2'h2
`define DRVSF_PAR_NONE1 2'h3
`define DRVSF_MEM_DEPTH 256
`endif

// *** drvsf_pkg.sv ***
package drvsf_pkg;
  `include "drvsf_regs.svh"
  typedef enum logic [2:0] {
    RX_HUNT, RX_LEN, RX_ADR, RX_DATA, RX_CHK
  } drvsf_rxst_t;
  typedef enum logic [1:0] {M_IDLE, M_SEND, M_WAIT} drvsf_mst_t;

  function automatic logic [16:0] drvsf_bit_cycles(input logic [2:0] sel,
                                                   input int hz);
    case (sel)
      3'h0: return 17'(hz / `DRVSF_BAUD0);
      3'h1: return 17'(hz / `DRVSF_BAUD1);
      3'h2: return 17'(hz / `DRVSF_BAUD2);
      3'h3: return 17'(hz / `DRVSF_BAUD3);
      3'h4: return 17'(hz / `DRVSF_BAUD4);
      3'h5: return 17'(hz / `DRVSF_BAUD5);
      3'h6: return 17'(hz / `DRVSF_BAUD6);
      default: return 17'(hz / `DRVSF_BAUD7);
    endcase
  endfunction

  // line bits lsb first: start, data, parity, stop(s), idle ones above
  function automatic logic [11:0] drvsf_char(input logic [7:0] d,
                                             input logic [1:0] cfg);
    logic p;
    p = ^d ^ (cfg == `DRVSF_PAR_ODD);
    if (cfg[1]) return {3'h7, d, 1'b0};
    return {2'h3, p, d, 1'b0};
  endfunction

  function automatic logic [3:0] drvsf_char_bits(input logic [1:0] cfg);
    return (cfg == `DRVSF_PAR_NONE1) ? 4'hA : 4'hB;
  endfunction

  // returns {broadcast, own address}
  function automatic logic [1:0] drvsf_addr_hit(input logic [7:0] a,
                                                input logic [6:0] n);
    if (a[7])
      return {a[6:0] == 7'h00, a[6:0] == n && n != 7'h00};
    return {a[5], !a[5] && a[4:0] == n[4:0] && n[6:5] == 2'h0 &&
            n != 7'h00};
  endfunction
endpackage

// *** drvsf_link_if.sv ***
`timescale 1ns/1ps
interface drvsf_link_if;
  logic m_tx;
  logic m_oe;
  logic s_tx;
  logic s_oe;
  logic line;
  // idle line floats high through the bias network
  assign line = m_oe ? m_tx : (s_oe ? s_tx : 1'b1);
  modport master (input line, output m_tx, output m_oe);
  modport slave (input line, output s_tx, output s_oe);
endinterface

// *** drvsf_slave.sv ***
`timescale 1ns/1ps
`include "drvsf_regs.svh"
// Behaviour
// [R1] one master, up to 126 distinct slaves
// [R2] slave transmits only to answer a request
// [R3] half-duplex, driver enabled only while replying
// [R4] master role never moves to another node
// [R5] short, long and text frame formats
// [R6] character: start, eight data, parity, stop
// [R7] data plus parity hold even ones
// [R8] parity/stop configurable, even one-stop default
// [R9] baud selectable 2400 to 115200
// [R10] frame opens with start character 02
// [R11] order: start, length, address, data, check
// [R12] length is data count plus two
// [R13] text frame length ten plus n; code sends length n plus two for every frame
// [R14] accept short or long address range
// [R15] short format: bit5 broadcast, bits0-4 node
// [R16] long format: bits0-6 node, zero broadcast
// [R17] reply echoes request address byte unchanged
// [R18] wait minimum delay before replying
// [R19] master bounds wait for reply
// [R20] receiver times out on long byte gap
// [R21] check byte is xor, cleared per frame
// [R22] drop bad or foreign frames, no reply
// [R23] timeout drops partial frame, hunt start
module drvsf_slave #(parameter int CLK_HZ = `DRVSF_CLK_HZ) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  drvsf_link_if.slave link,
  input wire logic [6:0] node_addr_i,
  input wire logic [2:0] baud_sel_i,
  input wire logic [1:0] par_cfg_i,
  input wire logic [31:0] min_dly_i,
  input wire logic [31:0] max_gap_i,
  output logic req_ok_o,
  output logic req_bcast_o,
  output logic [7:0] req_cnt_o,
  output logic [7:0] req_adr_o,
  input wire logic [7:0] rd_idx_i,
  output logic [7:0] rd_data_o,
  input wire logic rsp_wr_i,
  input wire logic [7:0] rsp_idx_i,
  input wire logic [7:0] rsp_data_i,
  input wire logic rsp_go_i,
  input wire logic [7:0] rsp_cnt_i,
  output logic pend_o,
  output logic tx_busy_o,
  output logic perr_o,
  output logic chk_err_o,
  output logic gap_to_o
);
  import drvsf_pkg::*;

  logic [7:0] req_mem [0:`DRVSF_MEM_DEPTH-1];
  logic [7:0] rsp_mem [0:`DRVSF_MEM_DEPTH-1];
  logic [1:0] sync_r;
  logic rxd;
  logic [16:0] bitc;
  logic rx_busy_r, rx_stb_r, rx_perr_r;
  logic [16:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_byte_r;
  drvsf_rxst_t st_r;
  logic [7:0] len_r, cnt_r, csum_r;
  logic [31:0] gap_r, since_r;
  logic pend_r, go_r, tx_on_r;
  logic [11:0] tx_sh_r;
  logic [3:0] tx_left_r;
  logic [16:0] tx_cnt_r;
  logic [8:0] tx_idx_r, tx_off;
  logic [7:0] tx_n_r, bcc_r, tx_byte;
  logic [1:0] hit;
  logic start_tx;

  assign bitc = drvsf_bit_cycles(baud_sel_i, CLK_HZ); // [R9]
  assign rxd = sync_r[1];
  assign link.s_tx = tx_sh_r[0];
  assign link.s_oe = tx_on_r; // [R3]
  assign tx_busy_o = tx_on_r;
  assign pend_o = pend_r;
  assign hit = drvsf_addr_hit(req_adr_o, node_addr_i); // [R14]

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) sync_r <= 2'h3;
    else if (en_i) sync_r <= {sync_r[0], link.line};
  end

  // character receiver, sampling mid-bit
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_busy_r <= 1'b0;
      rx_stb_r <= 1'b0;
      rx_perr_r <= 1'b0;
      rx_cnt_r <= 17'h00000;
      rx_bit_r <= 4'h0;
      rx_byte_r <= 8'h00;
    end else if (en_i) begin
      rx_stb_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rxd && !tx_on_r) begin // [R3]
          rx_busy_r <= 1'b1;
          rx_cnt_r <= bitc >> 1;
          rx_bit_r <= 4'h0;
          rx_perr_r <= 1'b0;
        end
      end else if (rx_cnt_r != 17'h00000) begin
        rx_cnt_r <= rx_cnt_r - 17'h00001;
      end else begin
        rx_cnt_r <= bitc - 17'h00001;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0 && rxd) rx_busy_r <= 1'b0;
        else if (rx_bit_r < 4'h9) rx_byte_r <= {rxd, rx_byte_r[7:1]}; // [R6]
        else if (rx_bit_r == 4'h9 && !par_cfg_i[1])
          rx_perr_r <= ^rx_byte_r ^ rxd ^ (par_cfg_i == `DRVSF_PAR_ODD); // [R7]
        else begin
          rx_perr_r <= rx_perr_r | !rxd;
          rx_busy_r <= 1'b0;
          rx_stb_r <= 1'b1;
        end
      end
    end
  end

  // frame parser
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= RX_HUNT;
      len_r <= 8'h00;
      cnt_r <= 8'h00;
      csum_r <= 8'h00;
      gap_r <= 32'h00000000;
      req_ok_o <= 1'b0;
      req_bcast_o <= 1'b0;
      req_cnt_o <= 8'h00;
      req_adr_o <= 8'h00;
      perr_o <= 1'b0;
      chk_err_o <= 1'b0;
      gap_to_o <= 1'b0;
    end else if (en_i) begin
      req_ok_o <= 1'b0;
      perr_o <= 1'b0;
      chk_err_o <= 1'b0;
      gap_to_o <= 1'b0;
      if (st_r == RX_HUNT || rx_busy_r || rx_stb_r) gap_r <= 32'h00000000;
      else gap_r <= gap_r + 32'h00000001;
      if (st_r != RX_HUNT && gap_r >= max_gap_i && !rx_busy_r) begin
        st_r <= RX_HUNT; // [R20] [R23]
        gap_to_o <= 1'b1;
      end else if (rx_stb_r && rx_perr_r) begin
        perr_o <= st_r != RX_HUNT;
        st_r <= RX_HUNT; // [R22]
      end else if (rx_stb_r) begin
        csum_r <= csum_r ^ rx_byte_r; // [R21]
        case (st_r)
          RX_HUNT: begin
            csum_r <= rx_byte_r; // [R21]
            if (rx_byte_r == `DRVSF_START_CHAR) st_r <= RX_LEN; // [R10]
          end
          RX_LEN: begin
            len_r <= rx_byte_r; // [R12] [R13]
            st_r <= (rx_byte_r < `DRVSF_LEN_OVH) ? RX_HUNT : RX_ADR;
          end
          RX_ADR: begin
            req_adr_o <= rx_byte_r;
            cnt_r <= 8'h00;
            st_r <= (len_r == `DRVSF_LEN_OVH) ? RX_CHK : RX_DATA; // [R11]
          end
          RX_DATA: begin
            req_mem[cnt_r] <= rx_byte_r; // [R5]
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r + 8'h01 == len_r - `DRVSF_LEN_OVH) st_r <= RX_CHK;
          end
          RX_CHK: begin
            st_r <= RX_HUNT;
            req_cnt_o <= cnt_r;
            if (csum_r != rx_byte_r) chk_err_o <= 1'b1; // [R22]
            else if (hit != 2'h0) begin // [R15] [R16]
              req_ok_o <= 1'b1;
              req_bcast_o <= hit[1];
            end
          end
          default: st_r <= RX_HUNT;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (en_i) rd_data_o <= req_mem[rd_idx_i];
    if (en_i && rsp_wr_i) rsp_mem[rsp_idx_i] <= rsp_data_i;
  end

  // reply permission and turnaround delay
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_r <= 1'b0;
      go_r <= 1'b0;
      since_r <= 32'h00000000;
      tx_n_r <= 8'h00;
    end else if (en_i) begin
      if (req_ok_o) since_r <= 32'h00000000;
      else if (since_r != 32'hFFFFFFFF) since_r <= since_r + 32'h00000001;
      if (req_ok_o && !req_bcast_o) pend_r <= 1'b1; // [R2]
      else if (start_tx || (st_r == RX_LEN && !tx_on_r)) pend_r <= 1'b0;
      if (start_tx || !pend_r) go_r <= 1'b0;
      else if (rsp_go_i) begin
        go_r <= 1'b1; // [R2]
        tx_n_r <= rsp_cnt_i;
      end
    end
  end

  assign start_tx = pend_r && go_r && !tx_on_r && st_r == RX_HUNT &&
                    !rx_busy_r && since_r >= min_dly_i; // [R18]

  assign tx_off = tx_idx_r - 9'h003;
  always_comb begin
    if (tx_idx_r == 9'h000) tx_byte = `DRVSF_START_CHAR; // [R10] [R11]
    else if (tx_idx_r == 9'h001) tx_byte = tx_n_r + `DRVSF_LEN_OVH; // [R12]
    else if (tx_idx_r == 9'h002) tx_byte = req_adr_o; // [R17]
    else if (tx_idx_r < {1'b0, tx_n_r} + 9'h003) tx_byte = rsp_mem[tx_off[7:0]];
    else tx_byte = bcc_r; // [R21]
  end

  // reply transmitter
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_on_r <= 1'b0;
      tx_sh_r <= 12'hFFF;
      tx_left_r <= 4'h0;
      tx_cnt_r <= 17'h00000;
      tx_idx_r <= 9'h000;
      bcc_r <= 8'h00;
    end else if (en_i) begin
      if (start_tx) begin
        tx_on_r <= 1'b1; // [R3]
        tx_idx_r <= 9'h000;
        bcc_r <= 8'h00; // [R21]
      end else if (tx_on_r && tx_left_r == 4'h0) begin
        if (tx_idx_r == {1'b0, tx_n_r} + 9'h004) tx_on_r <= 1'b0;
        else begin
          tx_sh_r <= drvsf_char(tx_byte, par_cfg_i); // [R6] [R7] [R8]
          tx_left_r <= drvsf_char_bits(par_cfg_i);
          tx_cnt_r <= bitc - 17'h00001;
          bcc_r <= bcc_r ^ tx_byte; // [R21]
          tx_idx_r <= tx_idx_r + 9'h001;
        end
      end else if (tx_cnt_r != 17'h00000) begin
        tx_cnt_r <= tx_cnt_r - 17'h00001;
      end else if (tx_left_r != 4'h0) begin
        tx_sh_r <= {1'b1, tx_sh_r[11:1]};
        tx_left_r <= tx_left_r - 4'h1;
        tx_cnt_r <= bitc - 17'h00001;
      end
    end
  end
endmodule

// *** drvsf_master.sv ***
`timescale 1ns/1ps
`include "drvsf_regs.svh"
module drvsf_master #(parameter int CLK_HZ = `DRVSF_CLK_HZ) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  drvsf_link_if.master link,
  input wire logic [2:0] baud_sel_i,
  input wire logic [1:0] par_cfg_i,
  input wire logic [31:0] max_gap_i,
  input wire logic [31:0] max_resp_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_idx_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_go_i,
  input wire logic [7:0] cmd_adr_i,
  input wire logic [7:0] cmd_cnt_i,
  output logic busy_o,
  output logic rsp_ok_o,
  output logic rsp_to_o,
  output logic rsp_err_o,
  output logic [7:0] rsp_cnt_o,
  input wire logic [7:0] rd_idx_i,
  output logic [7:0] rd_data_o
);
  import drvsf_pkg::*;

  logic [7:0] cmd_mem [0:`DRVSF_MEM_DEPTH-1];
  logic [7:0] rsp_mem [0:`DRVSF_MEM_DEPTH-1];
  logic [1:0] sync_r;
  logic rxd;
  logic [16:0] bitc, rx_cnt_r, tx_cnt_r;
  logic rx_busy_r, rx_stb_r, rx_perr_r;
  logic [3:0] rx_bit_r, tx_left_r;
  logic [7:0] rx_byte_r, len_r, cnt_r, csum_r, adr_r, n_r, bcc_r, tx_byte;
  drvsf_rxst_t st_r;
  drvsf_mst_t ms_r;
  logic [31:0] tmr_r;
  logic [11:0] tx_sh_r;
  logic [8:0] tx_idx_r, tx_off;
  logic hold;

  assign bitc = drvsf_bit_cycles(baud_sel_i, CLK_HZ); // [R9]
  // wait a bit time after a reply so the slave has let go of the wire
  assign hold = rx_busy_r || tmr_r < {15'h0, bitc}; // [R3]
  assign rxd = sync_r[1];
  assign link.m_tx = tx_sh_r[0];
  assign link.m_oe = ms_r == M_SEND; // [R3] [R4]
  assign busy_o = ms_r != M_IDLE || hold;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) sync_r <= 2'h3;
    else if (en_i) sync_r <= {sync_r[0], link.line};
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_busy_r <= 1'b0;
      rx_stb_r <= 1'b0;
      rx_perr_r <= 1'b0;
      rx_cnt_r <= 17'h00000;
      rx_bit_r <= 4'h0;
      rx_byte_r <= 8'h00;
    end else if (en_i) begin
      rx_stb_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rxd && ms_r == M_WAIT) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= bitc >> 1;
          rx_bit_r <= 4'h0;
          rx_perr_r <= 1'b0;
        end
      end else if (rx_cnt_r != 17'h00000) begin
        rx_cnt_r <= rx_cnt_r - 17'h00001;
      end else begin
        rx_cnt_r <= bitc - 17'h00001;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0 && rxd) rx_busy_r <= 1'b0;
        else if (rx_bit_r < 4'h9) rx_byte_r <= {rxd, rx_byte_r[7:1]}; // [R6]
        else if (rx_bit_r == 4'h9 && !par_cfg_i[1])
          rx_perr_r <= ^rx_byte_r ^ rxd ^ (par_cfg_i == `DRVSF_PAR_ODD); // [R7]
        else begin
          rx_perr_r <= rx_perr_r | !rxd;
          rx_busy_r <= 1'b0;
          rx_stb_r <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (en_i) rd_data_o <= rsp_mem[rd_idx_i];
    if (en_i && cmd_wr_i) cmd_mem[cmd_idx_i] <= cmd_data_i;
    if (en_i && rx_stb_r && st_r == RX_DATA) rsp_mem[cnt_r] <= rx_byte_r;
  end

  assign tx_off = tx_idx_r - 9'h003;
  always_comb begin
    if (tx_idx_r == 9'h000) tx_byte = `DRVSF_START_CHAR; // [R10] [R11]
    else if (tx_idx_r == 9'h001) tx_byte = n_r + `DRVSF_LEN_OVH; // [R12] [R13]
    else if (tx_idx_r == 9'h002) tx_byte = adr_r; // [R1] [R15] [R16]
    else if (tx_idx_r < {1'b0, n_r} + 9'h003) tx_byte = cmd_mem[tx_off[7:0]];
    else tx_byte = bcc_r; // [R21]
  end

  // request sender, reply wait and reply parser
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ms_r <= M_IDLE;
      st_r <= RX_HUNT;
      tx_sh_r <= 12'hFFF;
      tx_left_r <= 4'h0;
      tx_cnt_r <= 17'h00000;
      tx_idx_r <= 9'h000;
      {adr_r, n_r, bcc_r, len_r, cnt_r, csum_r, rsp_cnt_o} <= 56'h0;
      tmr_r <= 32'hFFFFFFFF;
      {rsp_ok_o, rsp_to_o, rsp_err_o} <= 3'h0;
    end else if (en_i) begin
      {rsp_ok_o, rsp_to_o, rsp_err_o} <= 3'h0;
      if (rx_busy_r || rx_stb_r) tmr_r <= 32'h00000000;
      else if (tmr_r != 32'hFFFFFFFF) tmr_r <= tmr_r + 32'h00000001;
      case (ms_r)
        M_IDLE: if (cmd_go_i && !hold) begin // [R3]
          ms_r <= M_SEND;
          adr_r <= cmd_adr_i;
          n_r <= cmd_cnt_i;
          tx_idx_r <= 9'h000;
          bcc_r <= 8'h00; // [R21]
        end
        M_SEND: if (tx_left_r == 4'h0) begin
          if (tx_idx_r == {1'b0, n_r} + 9'h004) begin
            st_r <= RX_HUNT;
            tmr_r <= 32'h00000000;
            if (drvsf_addr_hit(adr_r, 7'h00) != 2'h0) ms_r <= M_IDLE;
            else ms_r <= M_WAIT;
          end else begin
            tx_sh_r <= drvsf_char(tx_byte, par_cfg_i); // [R6] [R7]
            tx_left_r <= drvsf_char_bits(par_cfg_i);
            tx_cnt_r <= bitc - 17'h00001;
            bcc_r <= bcc_r ^ tx_byte;
            tx_idx_r <= tx_idx_r + 9'h001;
          end
        end else if (tx_cnt_r != 17'h00000) begin
          tx_cnt_r <= tx_cnt_r - 17'h00001;
        end else begin
          tx_sh_r <= {1'b1, tx_sh_r[11:1]};
          tx_left_r <= tx_left_r - 4'h1;
          tx_cnt_r <= bitc - 17'h00001;
        end
        M_WAIT: begin
          if (!rx_busy_r && ((st_r == RX_HUNT && tmr_r >= max_resp_i) ||
              (st_r != RX_HUNT && tmr_r >= max_gap_i))) begin
            ms_r <= M_IDLE; // [R19] [R20]
            rsp_to_o <= 1'b1;
          end else if (rx_stb_r && rx_perr_r) begin
            ms_r <= M_IDLE;
            rsp_err_o <= 1'b1;
          end else if (rx_stb_r) begin
            csum_r <= csum_r ^ rx_byte_r;
            case (st_r)
              RX_HUNT: begin
                csum_r <= rx_byte_r; // [R21]
                if (rx_byte_r == `DRVSF_START_CHAR) st_r <= RX_LEN;
              end
              RX_LEN: begin
                len_r <= rx_byte_r;
                st_r <= (rx_byte_r < `DRVSF_LEN_OVH) ? RX_HUNT : RX_ADR;
              end
              RX_ADR: begin
                cnt_r <= 8'h00;
                if (rx_byte_r != adr_r) begin // [R17]
                  ms_r <= M_IDLE;
                  rsp_err_o <= 1'b1;
                end
                st_r <= (len_r == `DRVSF_LEN_OVH) ? RX_CHK : RX_DATA;
              end
              RX_DATA: begin
                cnt_r <= cnt_r + 8'h01; // [R5]
                if (cnt_r + 8'h01 == len_r - `DRVSF_LEN_OVH) st_r <= RX_CHK;
              end
              default: begin
                ms_r <= M_IDLE;
                st_r <= RX_HUNT;
                rsp_cnt_o <= cnt_r;
                rsp_ok_o <= csum_r == rx_byte_r;
                rsp_err_o <= csum_r != rx_byte_r;
              end
            endcase
          end
        end
        default: ms_r <= M_IDLE;
      endcase
    end
  end
endmodule

// *** drvsf_link_sva.sv ***
`timescale 1ns/1ps
module drvsf_link_sva #(
  parameter int BITC = 2170,
  parameter int MIN_DLY = 5000
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic m_tx,
  input wire logic m_oe,
  input wire logic s_tx,
  input wire logic s_oe,
  input wire logic line
);
  localparam int FRAME_MIN = 44 * BITC;
  localparam int DLY_MIN = MIN_DLY - BITC;
  logic [31:0] low_r;
  logic [31:0] m_on_r;
  logic [31:0] s_on_r;
  logic [31:0] quiet_r;
  logic m_oe_q_r;
  logic req_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // length of the current low run on the wire
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) low_r <= '0;
    else low_r <= line ? 32'h0 : low_r + 32'h1;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) m_on_r <= '0;
    else m_on_r <= m_oe ? m_on_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) s_on_r <= '0;
    else s_on_r <= s_oe ? s_on_r + 32'h1 : 32'h0;
  end
  // cycles since the master released the wire
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) quiet_r <= '0;
    else quiet_r <= m_oe ? 32'h0 : quiet_r + 32'h1;
  end
  // a request was sent and not yet answered
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      m_oe_q_r <= 1'b0;
      req_r <= 1'b0;
    end else begin
      m_oe_q_r <= m_oe;
      if (m_oe_q_r && !m_oe) req_r <= 1'b1;
      else if (s_oe) req_r <= 1'b0;
    end
  end
  property p_half_duplex;
    !(m_oe && s_oe);
  endproperty
  a_half_duplex: assert property (p_half_duplex)
    else $error("both ends drive the wire");
  property p_m_idle;
    !m_oe |-> m_tx;
  endproperty
  a_m_idle: assert property (p_m_idle)
    else $error("master tx not idle high");
  property p_s_idle;
    !s_oe |-> s_tx;
  endproperty
  a_s_idle: assert property (p_s_idle)
    else $error("slave tx not idle high");
  property p_m_start;
    $rose(m_oe) |-> m_tx ##1 !m_tx;
  endproperty
  a_m_start: assert property (p_m_start)
    else $error("master start bit misplaced");
  property p_s_start;
    $rose(s_oe) |-> s_tx ##1 !s_tx ##[1:2] !line;
  endproperty
  a_s_start: assert property (p_s_start)
    else $error("slave start bit misplaced");
  property p_bit_time;
    $rose(line) |-> low_r >= BITC;
  endproperty
  a_bit_time: assert property (p_bit_time)
    else $error("low run shorter than one bit");
  property p_reply_after_req;
    $rose(s_oe) |-> req_r;
  endproperty
  a_reply_after_req: assert property (p_reply_after_req)
    else $error("slave sent without a request");
  property p_min_dly;
    $rose(s_oe) |-> quiet_r >= DLY_MIN;
  endproperty
  a_min_dly: assert property (p_min_dly)
    else $error("reply started too early");
  property p_m_frame;
    $fell(m_oe) |-> m_on_r >= FRAME_MIN && $past(m_tx);
  endproperty
  a_m_frame: assert property (p_m_frame)
    else $error("request frame too short");
  property p_s_frame;
    $fell(s_oe) |-> s_on_r >= FRAME_MIN && $past(s_tx);
  endproperty
  a_s_frame: assert property (p_s_frame)
    else $error("reply frame too short");
  c_reply: cover property ($rose(s_oe));
  c_request: cover property ($fell(m_oe));
  c_turn: cover property (req_r && $rose(s_oe));
endmodule

// *** test_drive_serial_frame_slave.sv ***
`timescale 1ns/1ps
module test_drive_serial_frame_slave;
  import drvsf_pkg::*;
  // scaled reference rate: one bit lasts 8 cycles at the top baud rate
  localparam int CLK_HZ = 921600;
  localparam int BITC = CLK_HZ / 115200;
  localparam int MIN_DLY = 50;
  localparam int LIMIT = 40000;
  logic clk_i, resetn_i, cmd_wr, cmd_go, rsp_wr, rsp_go, en;
  logic [2:0] baud;
  logic [1:0] par;
  logic [7:0] cmd_idx, cmd_data, cmd_adr, cmd_cnt, m_rd_idx;
  logic [7:0] rsp_idx, rsp_data, rsp_cnt, s_rd_idx;
  logic [6:0] node;
  logic busy, rsp_ok, rsp_to, rsp_err, req_ok, req_bcast, pend, tx_busy;
  logic perr, chk_err, gap_to;
  logic [7:0] m_cnt, m_rd_data, req_cnt, req_adr, s_rd_data;
  logic [7:0] dq[$];
  logic [7:0] exp_q[$];
  int num_errors = 0, comparisons = 0, cycles = 0, n_ok = 0, n_bad = 0;
  drvsf_link_if link_if ();
  drvsf_master #(.CLK_HZ(CLK_HZ)) drvsf_master_inst (.clk_i(clk_i),
    .resetn_i(resetn_i), .en_i(en), .link(link_if), .baud_sel_i(baud),
    .par_cfg_i(par), .max_gap_i(32'd100), .max_resp_i(32'd400),
    .cmd_wr_i(cmd_wr),
    .cmd_idx_i(cmd_idx), .cmd_data_i(cmd_data), .cmd_go_i(cmd_go),
    .cmd_adr_i(cmd_adr), .cmd_cnt_i(cmd_cnt), .busy_o(busy),
    .rsp_ok_o(rsp_ok), .rsp_to_o(rsp_to), .rsp_err_o(rsp_err),
    .rsp_cnt_o(m_cnt), .rd_idx_i(m_rd_idx), .rd_data_o(m_rd_data));
  drvsf_slave #(.CLK_HZ(CLK_HZ)) drvsf_slave_inst (.clk_i(clk_i),
    .resetn_i(resetn_i), .en_i(en), .link(link_if), .node_addr_i(node),
    .baud_sel_i(baud), .par_cfg_i(par), .min_dly_i(MIN_DLY),
    .max_gap_i(32'd100),
    .req_ok_o(req_ok), .req_bcast_o(req_bcast), .req_cnt_o(req_cnt),
    .req_adr_o(req_adr), .rd_idx_i(s_rd_idx), .rd_data_o(s_rd_data),
    .rsp_wr_i(rsp_wr), .rsp_idx_i(rsp_idx), .rsp_data_i(rsp_data),
    .rsp_go_i(rsp_go), .rsp_cnt_i(rsp_cnt), .pend_o(pend),
    .tx_busy_o(tx_busy), .perr_o(perr), .chk_err_o(chk_err),
    .gap_to_o(gap_to));
  drvsf_link_sva #(.BITC(BITC), .MIN_DLY(MIN_DLY)) drvsf_link_sva_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .m_tx(link_if.m_tx),
    .m_oe(link_if.m_oe), .s_tx(link_if.s_tx), .s_oe(link_if.s_oe),
    .line(link_if.line));
  task automatic check(input logic [7:0] seen, exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen,
               exp);
    end
  endtask
  task automatic conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // queue the bytes the wire should carry for dq under this address
  task automatic put_frame(input logic [7:0] adr);
    logic [7:0] x;
    x = 8'h02 ^ 8'(dq.size() + 2) ^ adr;
    exp_q.push_back(8'h02);
    exp_q.push_back(8'(dq.size() + 2));
    exp_q.push_back(adr);
    foreach (dq[i]) begin
      exp_q.push_back(dq[i]);
      x = x ^ dq[i];
    end
    exp_q.push_back(x);
  endtask
  task automatic xfer(input logic [7:0] adr, input int n, input bit hit,
                      input bit bc);
    int ok0;
    int m;
    ok0 = n_ok;
    dq.delete();
    for (int i = 0; i < n; i++) dq.push_back(8'($urandom));
    put_frame(adr);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      cmd_wr <= 1'b1;
      cmd_idx <= 8'(i);
      cmd_data <= dq[i];
    end
    @(posedge clk_i);
    cmd_wr <= 1'b0;
    @(negedge clk_i iff busy === 1'b0);
    @(posedge clk_i);
    cmd_go <= 1'b1;
    cmd_adr <= adr;
    cmd_cnt <= 8'(n);
    @(posedge clk_i);
    cmd_go <= 1'b0;
    if (!hit) begin
      @(negedge clk_i iff (rsp_ok | rsp_to | rsp_err) === 1'b1);
      check(8'(rsp_to), 8'h1, "foreign timeout");
      check(8'(n_ok - ok0), 8'h0, "foreign accepted");
      return;
    end
    @(negedge clk_i iff req_ok === 1'b1);
    check(req_adr, adr, "req address");
    check(req_cnt, 8'(n), "req count");
    check(8'(req_bcast), 8'(bc), "broadcast flag");
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      s_rd_idx <= 8'(i);
      @(posedge clk_i);
      @(negedge clk_i);
      check(s_rd_data, dq[i], "req data");
    end
    if (bc) begin
      @(negedge clk_i iff busy === 1'b0);
      repeat (2 * MIN_DLY) @(negedge clk_i);
      check(8'(pend), 8'h0, "broadcast pending");
      check(8'(exp_q.size()), 8'h0, "broadcast bytes");
      return;
    end
    check(8'(pend), 8'h1, "pending");
    m = $urandom_range(3, 0);
    dq.delete();
    for (int i = 0; i < m; i++) dq.push_back(8'($urandom));
    put_frame(adr);
    for (int i = 0; i < m; i++) begin
      @(posedge clk_i);
      rsp_wr <= 1'b1;
      rsp_idx <= 8'(i);
      rsp_data <= dq[i];
    end
    @(posedge clk_i);
    rsp_wr <= 1'b0;
    rsp_go <= 1'b1;
    rsp_cnt <= 8'(m);
    @(posedge clk_i);
    rsp_go <= 1'b0;
    @(negedge clk_i iff (rsp_ok | rsp_to | rsp_err) === 1'b1);
    check(8'(rsp_ok), 8'h1, "reply accepted");
    check(m_cnt, 8'(m), "reply count");
    check(8'(pend), 8'h0, "pending after reply");
    for (int i = 0; i < m; i++) begin
      @(posedge clk_i);
      m_rd_idx <= 8'(i);
      @(posedge clk_i);
      @(negedge clk_i);
      check(m_rd_data, dq[i], "reply data");
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    n_ok += (req_ok === 1'b1);
    n_bad += ((perr | chk_err | gap_to) === 1'b1);
    if (cycles == LIMIT) begin
      num_errors++;
      conclude;
    end
  end
  // decodes every character on the wire and matches it to exp_q
  initial begin
    logic [10:0] b;
    forever begin
      @(negedge clk_i iff link_if.line === 1'b0);
      for (int k = 0; k < 11; k++) begin
        repeat (k == 0 ? BITC / 2 : BITC) @(negedge clk_i);
        b[k] = link_if.line;
      end
      check(8'(b[0]), 8'h0, "start bit");
      check(8'(b[10]), 8'h1, "stop bit");
      check(8'(^b[9:1]), 8'(par == 2'h1), "parity");
      if (exp_q.size() == 0) check(b[8:1], 8'hXX, "stray byte");
      else check(b[8:1], exp_q.pop_front(), "frame byte");
    end
  end
  initial begin
    resetn_i = 1'b0;
    {cmd_wr, cmd_go, rsp_wr, rsp_go} = 4'h0;
    {en, baud, par} = {1'b1, 3'h7, 2'h0};
    {cmd_idx, cmd_data, cmd_adr, cmd_cnt, m_rd_idx} = '0;
    {rsp_idx, rsp_data, rsp_cnt, s_rd_idx} = '0;
    void'($urandom(84));
    node = 7'($urandom_range(30, 1));
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    check(8'(link_if.line), 8'h1, "idle wire");
    check(8'({busy, pend}), 8'h0, "reset state");
    xfer({1'b1, node}, 2, 1, 0);
    @(posedge clk_i);
    par <= 2'h1;
    xfer({2'b01, 1'b0, node[4:0]}, 4, 1, 0);
    xfer(8'h20 | 8'($urandom_range(31, 0)), 0, 1, 1);
    xfer(8'h80, 1, 1, 1);
    xfer({1'b1, node + 7'h1}, 0, 0, 0);
    check(8'(n_bad), 8'h0, "error pulses");
    conclude;
  end
endmodule
